// ### dv/crs_core_regs_assertions.sv
// port-level assertions for the core register set
module crs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] wr_data,
  input wire crs_pkg::crs_sel_t wr_sel,
  input wire logic wr_en,
  input wire logic sp_load,
  input wire crs_pkg::crs_stack_op_t stack_op,
  input wire logic [7:0] operand,
  input wire crs_pkg::crs_sel_t idx_sel,
  input wire logic [7:0] opcode,
  input wire logic [7:0] acc_q,
  input wire logic [7:0] idx1_q,
  input wire logic [7:0] idx2_q,
  input wire logic [7:0] sp_q,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] eff_addr,
  input wire logic halt_oscillator_instr,
  input wire logic unusable_instr
);
  import crs_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_acc_load: assert property (wr_en && wr_sel == CRS_SEL_ACC |=> acc_q == $past(wr_data))
    else $error("acc load");
  // a write in the same cycle is excluded, though the sum uses the index value from before that write
  a_eff_first: assert property (!wr_en && idx_sel != CRS_SEL_IDX2 |=>
    eff_addr == 8'($past(operand) + $past(idx1_q))) else $error("eff idx1");
  a_eff_second: assert property (!wr_en && idx_sel == CRS_SEL_IDX2 |=>
    eff_addr == 8'($past(operand) + $past(idx2_q))) else $error("eff idx2");
  a_sp_load: assert property (sp_load |=> sp_q == $past(wr_data))
    else $error("sp load");
  a_push_order: assert property (!sp_load && stack_op == CRS_ST_PUSH |=>
    sp_q == $past(sp_q) - 8'h01 && stack_addr[7:0] == $past(sp_q)) else $error("push");
  a_pop_order: assert property (!sp_load && stack_op == CRS_ST_POP |=>
    sp_q == $past(sp_q) + 8'h01 && stack_addr[7:0] == sp_q) else $error("pop");
  a_halt_decode: assert property (opcode == 8'h42 |=> halt_oscillator_instr && !unusable_instr)
    else $error("halt decode");
  a_clk_refused: assert property (opcode == 8'hE2 || opcode == 8'h9A |=> unusable_instr)
    else $error("unusable decode");
endmodule
bind crs_core_regs crs_chk i_crs_chk (.clk, .rst_n, .wr_data, .wr_sel, .wr_en, .sp_load,
  .stack_op, .operand, .idx_sel, .opcode, .acc_q, .idx1_q, .idx2_q, .sp_q, .stack_addr,
  .eff_addr, .halt_oscillator_instr, .unusable_instr);

// ### dv/tb.sv
// random and directed test of the core register set
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import crs_pkg::*;
  logic clk, rst_n, wr_en, sp_load, mem_wr, pc_load, pc_inc;
  logic [7:0] wr_data, operand, opcode, acc_q, idx1_q, idx2_q, sp_q, eff_addr;
  logic [7:0] prog_counter_high, prog_counter_low, processor_mode_reg;
  logic [7:0] m_sp, m_acc, m_x1, m_x2, m_eff, m_sa;
  logic [15:0] mem_addr, pc_load_val, stack_addr, m_pc, m_pcd;
  logic halt_oscillator_instr, wait_for_interrupt_instr, product_instr;
  logic quotient_instr, unusable_instr;
  crs_sel_t wr_sel, idx_sel;
  crs_stack_op_t stack_op;
  int n_mismatch, tests_run, cyc;
  logic [7:0] ops [6] = '{8'h42, 8'hC2, 8'h02, 8'h22, 8'hE2, 8'h9A};
  crs_core_regs i_crs_core_regs (.clk, .rst_n, .wr_data, .wr_sel, .wr_en, .sp_load, .stack_op,
    .operand, .idx_sel, .mem_wr, .mem_addr, .pc_load, .pc_load_val, .pc_inc, .opcode, .acc_q,
    .idx1_q, .idx2_q, .sp_q, .stack_addr, .eff_addr, .prog_counter_high, .prog_counter_low,
    .processor_mode_reg, .halt_oscillator_instr, .wait_for_interrupt_instr, .product_instr,
    .quotient_instr, .unusable_instr);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ceiling well above the roughly 530 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  function logic [7:0] sp_next(input logic [7:0] s);
    if (sp_load)
      return wr_data;
    return stack_op == CRS_ST_PUSH ? s - 8'h01 : stack_op == CRS_ST_POP ? s + 8'h01 : s;
  endfunction
  function logic [15:0] dec_exp(input int i);
    return i < 4 ? 16'h0010 >> i : 16'h0001;
  endfunction
  initial
  begin
    {rst_n, wr_en, sp_load, mem_wr, pc_load, pc_inc, wr_data, operand, opcode} = '0;
    {mem_addr, pc_load_val} = '0;
    {wr_sel, idx_sel, stack_op} = {CRS_SEL_ACC, CRS_SEL_IDX1, CRS_ST_NONE};
    {m_sp, m_acc, m_x1, m_x2, m_eff} = {8'hFF, 32'h0000_0000};
    {m_pc, m_pcd, m_sa} = {32'h0000_0000, 8'hFF};
    void'($urandom(53));
    repeat (8) @(posedge clk);
    chk("sp_reset", sp_q, 8'hFF);
    rst_n <= 1'b1;
    repeat (500)
    begin
      @(posedge clk);
      {wr_en, pc_load, pc_inc, mem_wr} <= 4'($urandom);
      sp_load <= ($urandom % 5) == 0;
      {wr_data, operand, opcode} <= 24'($urandom);
      {mem_addr, pc_load_val} <= $urandom;
      wr_sel <= crs_sel_t'(3'b001 << ($urandom % 3));
      idx_sel <= crs_sel_t'(3'b001 << ($urandom % 3));
      stack_op <= crs_stack_op_t'(3'b001 << ($urandom % 3));
      @(negedge clk);
      chk("sp", sp_q, m_sp);
      chk("sp_addr", stack_addr[7:0], m_sa);
      chk("acc", acc_q, m_acc);
      chk("idx1", idx1_q, m_x1);
      chk("idx2", idx2_q, m_x2);
      chk("pc", {prog_counter_high, prog_counter_low}, m_pcd);
      chk("eff", eff_addr, m_eff);
      m_eff = operand + (idx_sel == CRS_SEL_IDX2 ? m_x2 : m_x1);
      m_pcd = m_pc;
      m_pc = pc_load ? pc_load_val : pc_inc ? m_pc + 16'h0001 : m_pc;
      m_sa = !sp_load && stack_op == CRS_ST_POP ? m_sp + 8'h01 : m_sp;
      m_sp = sp_next(m_sp);
      m_acc = wr_en && wr_sel == CRS_SEL_ACC ? wr_data : m_acc;
      m_x1 = wr_en && wr_sel == CRS_SEL_IDX1 ? wr_data : m_x1;
      m_x2 = wr_en && wr_sel == CRS_SEL_IDX2 ? wr_data : m_x2;
    end
    @(posedge clk);
    {mem_wr, sp_load, mem_addr, wr_data, stack_op} <= {2'b10, 16'h003B, 8'h04, CRS_ST_NONE};
    @(posedge clk);
    mem_wr <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("page", stack_addr[15:8], 8'h01);
    chk("mode", processor_mode_reg, 8'h04);
    foreach (ops[i])
    begin
      @(posedge clk);
      opcode <= ops[i];
      @(posedge clk);
      @(negedge clk);
      chk("decode", {halt_oscillator_instr, wait_for_interrupt_instr, product_instr,
        quotient_instr, unusable_instr}, dec_exp(i));
    end
    final_report();
  end
endmodule

// ### inc/crs_map.svh
// register set constants: reset values, stack page bytes, mode register bits, opcodes
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
`define CRS_ZERO8 8'h00
`define CRS_ONE8 8'h01
`define CRS_SP_RESET 8'hFF
`define CRS_PAGE0_HI 8'h00
`define CRS_PAGE1_HI 8'h01
`define CRS_MODE_ADDR 16'h003B
`define CRS_MODE_STACK_BIT 2
`define CRS_MODE_RESET 8'h00
`define CRS_PC_RESET 16'h0000
`define CRS_PC_STEP 16'h0001
`define CRS_OP_HALT_OSC 8'h42
`define CRS_OP_WAIT_INT 8'hC2
`define CRS_OP_PRODUCT 8'h02
`define CRS_OP_QUOTIENT 8'h22
`define CRS_OP_FAST_CLK 8'hE2
`define CRS_OP_SLOW_CLK 8'h9A
`endif

// ### inc/crs_pkg.sv
// types shared by the core register set
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_ST_NONE = 3'b001,
    CRS_ST_PUSH = 3'b010,
    CRS_ST_POP = 3'b100
  } crs_stack_op_t;

  typedef enum logic [2:0] {
    CRS_SEL_ACC = 3'b001,
    CRS_SEL_IDX1 = 3'b010,
    CRS_SEL_IDX2 = 3'b100
  } crs_sel_t;
endpackage

// ### rtl/crs_core_regs.sv
// core register set: accumulator, index pair, stack pointer, program counter, mode register
// What this block does
// [RULE1] eight-bit accumulator carries most data operations and transfers
// [RULE2] first index register; indexed address is operand plus its contents
// [RULE3] second index register; address is operand plus its contents
// [RULE4] eight-bit stack pointer for calls and interrupt entry
// [RULE5] stack address low byte comes straight from the stack pointer
// [RULE6] stack high byte is 00 for page bit 0, 01 for 1
// [RULE7] fast-clock and slow-clock opcodes are not decoded as usable
// [RULE8] oscillator stop, wait, multiply and divide opcodes are decoded
// [RULE9] software saves any register the hardware does not push itself
// [RULE10] stack page bit lives in the mode register at fixed address
// [RULE11] sixteen-bit program counter made of high and low bytes
// [RULE12] push stores then decrements; pop increments then reads
`include "crs_map.svh"
module crs_core_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] wr_data,
  input wire crs_pkg::crs_sel_t wr_sel,
  input wire logic wr_en,
  input wire logic sp_load,
  input wire crs_pkg::crs_stack_op_t stack_op,
  input wire logic [7:0] operand,
  input wire crs_pkg::crs_sel_t idx_sel,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  input wire logic pc_inc,
  input wire logic [7:0] opcode,
  output logic [7:0] acc_q,
  output logic [7:0] idx1_q,
  output logic [7:0] idx2_q,
  output logic [7:0] sp_q,
  output logic [15:0] stack_addr,
  output logic [7:0] eff_addr,
  output logic [7:0] prog_counter_high,
  output logic [7:0] prog_counter_low,
  output logic [7:0] processor_mode_reg,
  output logic halt_oscillator_instr,
  output logic wait_for_interrupt_instr,
  output logic product_instr,
  output logic quotient_instr,
  output logic unusable_instr
);
  import crs_pkg::*;

  logic [7:0] sp_reg;
  logic [7:0] sp_next;
  logic [7:0] mode_reg;
  logic [15:0] pc_reg;
  logic [7:0] sp_addr_byte;
  logic page_bit;
  logic [7:0] idx_val;

  // data registers share one write port; sp has its own path
  crs_reg8 u_acc (
    .clk(clk), .rst_n(rst_n),
    .load(wr_en && (wr_sel == CRS_SEL_ACC)), // RULE1
    .d(wr_data), .q(acc_q)
  );
  crs_reg8 u_idx1 (
    .clk(clk), .rst_n(rst_n),
    .load(wr_en && (wr_sel == CRS_SEL_IDX1)), // RULE2
    .d(wr_data), .q(idx1_q)
  );
  crs_reg8 u_idx2 (
    .clk(clk), .rst_n(rst_n),
    .load(wr_en && (wr_sel == CRS_SEL_IDX2)), // RULE3
    .d(wr_data), .q(idx2_q)
  );

  // push uses the current pointer, pop the incremented one
  always_comb
  begin
    sp_next = sp_reg;
    sp_addr_byte = sp_reg;
    if (sp_load)
      sp_next = wr_data; // RULE4
    else
      case (stack_op)
        CRS_ST_PUSH:
        begin
          sp_addr_byte = sp_reg; // RULE12
          sp_next = sp_reg - `CRS_ONE8; // RULE12
        end
        CRS_ST_POP:
        begin
          sp_addr_byte = sp_reg + `CRS_ONE8; // RULE12
          sp_next = sp_reg + `CRS_ONE8; // RULE12
        end
        CRS_ST_NONE: sp_next = sp_reg;
        default: sp_next = sp_reg;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sp_reg <= `CRS_SP_RESET;
    else
      sp_reg <= sp_next; // RULE4
  end

  // mode register is written by a store to its zero-page address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= `CRS_MODE_RESET;
    else if (mem_wr && (mem_addr == `CRS_MODE_ADDR))
      mode_reg <= wr_data; // RULE10
  end

  assign page_bit = mode_reg[`CRS_MODE_STACK_BIT];

  // load wins over increment so a jump never also steps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pc_reg <= `CRS_PC_RESET;
    else if (pc_load)
      pc_reg <= pc_load_val; // RULE11
    else if (pc_inc)
      pc_reg <= pc_reg + `CRS_PC_STEP; // RULE11
  end

  // registered outputs; stack address reflects the access of this cycle, one clock late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_q <= `CRS_SP_RESET;
      stack_addr <= {`CRS_PAGE0_HI, `CRS_SP_RESET};
      prog_counter_high <= `CRS_ZERO8;
      prog_counter_low <= `CRS_ZERO8;
      processor_mode_reg <= `CRS_MODE_RESET;
    end
    else
    begin
      sp_q <= sp_next;
      stack_addr[7:0] <= sp_addr_byte; // RULE5
      stack_addr[15:8] <= page_bit ? `CRS_PAGE1_HI : `CRS_PAGE0_HI; // RULE6
      prog_counter_high <= pc_reg[15:8]; // RULE11
      prog_counter_low <= pc_reg[7:0]; // RULE11
      processor_mode_reg <= mode_reg;
    end
  end

  // index 2 only on an explicit select; any other code falls back to index 1
  always_comb
  begin
    if (idx_sel == CRS_SEL_IDX2)
      idx_val = idx2_q; // RULE3
    else
      idx_val = idx1_q; // RULE2
  end

  // index add wraps in eight bits; page carry is the address unit's concern
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eff_addr <= `CRS_ZERO8;
    else
      eff_addr <= 8'(operand + idx_val); // RULE2 RULE3
  end

  // decode is registered, so the flags trail the opcode by one clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_oscillator_instr <= 1'b0;
      wait_for_interrupt_instr <= 1'b0;
      product_instr <= 1'b0;
      quotient_instr <= 1'b0;
      unusable_instr <= 1'b0;
    end
    else
    begin
      halt_oscillator_instr <= (opcode == `CRS_OP_HALT_OSC); // RULE8
      wait_for_interrupt_instr <= (opcode == `CRS_OP_WAIT_INT); // RULE8
      product_instr <= (opcode == `CRS_OP_PRODUCT); // RULE8
      quotient_instr <= (opcode == `CRS_OP_QUOTIENT); // RULE8
      // clock-speed opcodes are flagged so the sequencer treats them as unusable
      unusable_instr <= (opcode == `CRS_OP_FAST_CLK) || (opcode == `CRS_OP_SLOW_CLK); // RULE7
    end
  end
endmodule

// ### rtl/crs_reg8.sv
// one eight-bit data register with load strobe
`include "crs_map.svh"
module crs_reg8 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= `CRS_ZERO8;
    else if (load)
      q <= d;
  end
endmodule
